// file: rtl/ppm_manager.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppm_params.svh"
module ppm_manager
   import ppm_pkg::*;
#(
   parameter int MS_CYCLES = `PPM_MS_CYCLES,
   parameter int MIN_MS    = `PPM_MIN_MS
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // pack pins and analog comparators
   input  wire logic        charger_monitor_pin,
   input  wire logic        load_monitor_pin,
   input  wire logic        load_present,
   input  wire logic        current_detect,
   input  wire ppm_supply_t supply,
   input  wire logic [7:0]  cell_good,
   input  wire logic [7:0]  cell_below_sleep,
   input  wire logic [7:0]  cell_below_lockout,
   input  wire logic        fault_present,
   input  wire logic        balance_needed,
   // nonvolatile defaults and configuration
   input  wire logic [7:0]  nv_cell_map,
   input  wire logic [7:0]  mode_timer_setting,
   input  wire logic [7:0]  sleep_voltage_level,
   input  wire logic [7:0]  sleep_delay_ms,
   input  wire logic        lockout_powerdown_enable,
   // host mode control
   input  wire ppm_host_t   host,
   // outputs
   output ppm_state_t       state,
   output logic             supplies_on,
   output logic             fets_on,
   output logic             scan_strobe,
   output logic             balance_on,
   output logic [7:0]       cell_map
);
   logic ms_tick;
   logic min_tick;
   ppm_tick #(.MS_CYCLES(MS_CYCLES), .MIN_MS(MIN_MS)) u_tick (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ms_tick  (ms_tick),
      .min_tick (min_tick)
   );
   // pin synchronisers
   logic [1:0] chm_s;
   logic [1:0] ldm_s;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         chm_s <= 2'h0;
         ldm_s <= 2'h3;
      end else begin
         chm_s <= {chm_s[0], charger_monitor_pin};
         ldm_s <= {ldm_s[0], load_monitor_pin};
      end
   end
   logic chm;
   logic ldm_low;
   assign chm     = chm_s[1];
   assign ldm_low = ~ldm_s[1];
   // state registers
   ppm_state_t  next_state;
   logic [11:0] ms_cnt;
   logic [11:0] next_ms_cnt;
   logic [7:0]  min_cnt;
   logic [7:0]  next_min_cnt;
   logic [9:0]  scan_cnt;
   logic [9:0]  next_scan_cnt;
   logic [7:0]  slv_cnt;
   logic [7:0]  next_slv_cnt;
   logic [7:0]  uv_cnt;
   logic [7:0]  next_uv_cnt;
   logic [1:0]  pass_cnt;
   logic [1:0]  next_pass_cnt;
   logic [7:0]  next_cell_map;
   logic        next_fets;
   logic        next_supplies;
   logic        next_scan;
   logic        next_balance;
   logic        cells_ok;
   logic        low_v;
   logic        uv_any;
   logic        supply_fail;
   logic [3:0]  idle_min;
   logic [7:0]  sleep_min;
   logic [9:0]  scan_period;
   logic        no_auto;
   assign cells_ok    = ((cell_good & cell_map) == cell_map);
   assign low_v       = (sleep_voltage_level != 8'h0) && ((cell_below_sleep & cell_map) != 8'h0); // R17
   assign uv_any      = (cell_below_lockout & cell_map) != 8'h0;
   assign supply_fail = (~supply.supply_above_por & ~supply.regulator_output_ok) |
                        (~supply.supply_above_1v & supply.regulator_output_ok); // R8
   assign idle_min    = mode_timer_setting[3:0];
   assign sleep_min   = 8'(mode_timer_setting[7:4] * `PPM_SLEEP_STEP_MIN); // R18
   assign no_auto     = host.scan_override; // R12
   // mode sequencing
   always_comb begin
      next_state    = state;
      next_ms_cnt   = ms_cnt;
      next_min_cnt  = min_cnt;
      next_pass_cnt = pass_cnt;
      next_cell_map = cell_map;
      next_slv_cnt  = slv_cnt;
      next_uv_cnt   = uv_cnt;
      // low cell and lockout dwell timers
      if (!low_v) next_slv_cnt = 8'h0;
      else if (ms_tick && slv_cnt != 8'hff) next_slv_cnt = slv_cnt + 8'h1;
      if (!(uv_any && lockout_powerdown_enable)) next_uv_cnt = 8'h0;
      else if (ms_tick && uv_cnt != 8'hff) next_uv_cnt = uv_cnt + 8'h1;
      // inactivity minutes restart on any current
      if (current_detect) next_min_cnt = 8'h0; // R23
      else if (min_tick && min_cnt != 8'hff) next_min_cnt = min_cnt + 8'h1;
      case (state)
         PPM_POWER_DOWN: begin
            if (chm) begin // R1
               next_state    = PPM_POR_LOOP; // R2
               next_cell_map = nv_cell_map; // R7
            end
         end
         PPM_POR_LOOP: begin
            next_cell_map = nv_cell_map; // R7
            next_ms_cnt   = 12'h0;
            next_pass_cnt = 2'h0;
            if (cells_ok) next_state = PPM_LOAD_CHECK; // R3
         end
         PPM_LOAD_CHECK: begin
            if (ms_tick) next_ms_cnt = ms_cnt + 12'h1;
            if (!cells_ok) next_state = PPM_POR_LOOP;
            else if (ms_cnt >= 12'(`PPM_LOAD_WAIT_MS) && ms_tick) begin
               next_ms_cnt   = 12'(`PPM_LOAD_WAIT_MS - `PPM_LOAD_GAP_MS);
               next_pass_cnt = load_present ? 2'h0 : pass_cnt + 2'h1; // R6
               if (!load_present && pass_cnt + 2'h1 == `PPM_LOAD_PASSES) begin
                  next_state  = PPM_NORMAL;
                  next_min_cnt = 8'h0;
               end
            end
         end
         PPM_NORMAL, PPM_IDLE, PPM_DOZE: begin
            if (host.sleep) next_state = PPM_SLEEP; // R19 R24
            else if (host.doze) next_state = PPM_DOZE; // R15
            else if (host.idle) next_state = PPM_IDLE; // R13
            else if (current_detect) next_state = PPM_NORMAL; // R11
            else if (!no_auto) begin
               if (low_v && slv_cnt >= sleep_delay_ms) next_state = PPM_SLEEP; // R17
               else if (idle_min == 4'h0 && sleep_min == 8'h0)
                  next_state = PPM_SLEEP; // R20
               else if (state == PPM_NORMAL && idle_min == 4'h0)
                  next_state = PPM_DOZE; // R16
               else if (state == PPM_NORMAL && min_cnt >= 8'(idle_min)) begin
                  next_state   = PPM_IDLE; // R10
                  next_min_cnt = 8'h0;
               end else if (state == PPM_IDLE && min_cnt >= 8'(idle_min)) begin
                  next_state   = PPM_DOZE; // R14
                  next_min_cnt = 8'h0;
               end else if (state == PPM_DOZE && min_cnt >= sleep_min)
                  next_state = PPM_SLEEP; // R18
            end
         end
         PPM_SLEEP: begin
            if (!host.sleep && (ldm_low || chm || current_detect)) begin
               next_state   = PPM_NORMAL; // R21
               next_min_cnt = 8'h0;
            end
         end
         default: next_state = PPM_POWER_DOWN;
      endcase
      // power-down has top priority while operating
      if (state != PPM_POWER_DOWN &&
          (supply_fail || host.power_down || uv_cnt >= 8'(`PPM_UNDERVOLTAGE_LOCKOUT_THRESHOLD_MS))) // R8 R22
         next_state = PPM_POWER_DOWN;
   end
   // scan pacing and output drive
   always_comb begin
      case (state)
         PPM_IDLE: scan_period = 10'(`PPM_SCAN_IDLE_MS);
         PPM_DOZE: scan_period = 10'(`PPM_SCAN_DOZE_MS);
         default:  scan_period = 10'(`PPM_SCAN_NORMAL_MS);
      endcase
      next_scan_cnt = scan_cnt;
      next_scan     = 1'b0;
      if (ms_tick) next_scan_cnt = scan_cnt + 10'h1;
      if (ms_tick && scan_cnt + 10'h1 >= scan_period) begin // R9
         next_scan_cnt = 10'h0;
         next_scan = (state == PPM_NORMAL || state == PPM_IDLE || state == PPM_DOZE ||
                      state == PPM_LOAD_CHECK) && !no_auto; // R12
      end
      next_supplies = (next_state != PPM_POWER_DOWN); // R2 R21
      next_fets     = (next_state == PPM_NORMAL || next_state == PPM_IDLE ||
                       next_state == PPM_DOZE) && cells_ok && !fault_present; // R5
      next_balance  = (next_state == PPM_NORMAL) && balance_needed; // R9
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state       <= PPM_POWER_DOWN; // R1
         ms_cnt      <= 12'h0;
         min_cnt     <= 8'h0;
         pass_cnt    <= 2'h0;
         slv_cnt     <= 8'h0;
         uv_cnt      <= 8'h0;
         scan_cnt    <= 10'h0;
         cell_map    <= `PPM_CELLS_DEFAULT; // R4
         supplies_on <= 1'b0;
         fets_on     <= 1'b0;
         scan_strobe <= 1'b0;
         balance_on  <= 1'b0;
      end else begin
         state       <= next_state;
         ms_cnt      <= next_ms_cnt;
         min_cnt     <= next_min_cnt;
         pass_cnt    <= next_pass_cnt;
         slv_cnt     <= next_slv_cnt;
         uv_cnt      <= next_uv_cnt;
         scan_cnt    <= next_scan_cnt;
         cell_map    <= next_cell_map;
         supplies_on <= next_supplies;
         fets_on     <= next_fets;
         scan_strobe <= next_scan;
         balance_on  <= next_balance;
      end
   end
   // checks
   a_pd_wait: assert property (@(posedge clk) disable iff (sys_rst)
      (state == PPM_POWER_DOWN && !chm) |=> state == PPM_POWER_DOWN) // R1
      else $error("left power-down without charger");
   a_por_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (state == PPM_POR_LOOP && !cells_ok) |=> state inside {PPM_POR_LOOP, PPM_POWER_DOWN}) // R3
      else $error("left reset loop with bad cells");
   a_fet_good: assert property (@(posedge clk) disable iff (sys_rst)
      fets_on |-> $past(cells_ok) && !$past(fault_present)) // R5
      else $error("fets on with pack fault");
   a_sleep_force: assert property (@(posedge clk) disable iff (sys_rst)
      (host.sleep && state inside {PPM_NORMAL, PPM_IDLE, PPM_DOZE} && !supply_fail &&
       !host.power_down && uv_cnt < 8'(`PPM_UNDERVOLTAGE_LOCKOUT_THRESHOLD_MS)) |=> state == PPM_SLEEP) // R19
      else $error("sleep bit ignored");
   a_wake_normal: assert property (@(posedge clk) disable iff (sys_rst)
      (state inside {PPM_IDLE, PPM_DOZE} && current_detect && host[3:1] == 3'h0 &&
       !host.power_down && !supply_fail && uv_cnt < 8'(`PPM_UNDERVOLTAGE_LOCKOUT_THRESHOLD_MS))
      |=> state == PPM_NORMAL) // R11
      else $error("current did not restore normal");
   a_no_auto: assert property (@(posedge clk) disable iff (sys_rst)
      (state == PPM_NORMAL && no_auto && host[3:1] == 3'h0) |=> state inside
      {PPM_NORMAL, PPM_POWER_DOWN}) // R12
      else $error("automatic move under override");
   a_min_clear: assert property (@(posedge clk) disable iff (sys_rst)
      current_detect |=> min_cnt == 8'h0) // R23
      else $error("timer not restarted");
   a_pd_supply: assert property (@(posedge clk) disable iff (sys_rst)
      (supply_fail && state != PPM_POWER_DOWN) |=> state == PPM_POWER_DOWN) // R8
      else $error("supply fail ignored");
   // no scan pulse while the host owns scanning
   a_scan_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      no_auto |=> !scan_strobe) // R12
      else $error("scan pulse under override");
   // sleep holds while the host sleep bit stands
   a_sleep_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (state == PPM_SLEEP && host.sleep && !supply_fail && !host.power_down &&
       uv_cnt < 8'(`PPM_UNDERVOLTAGE_LOCKOUT_THRESHOLD_MS)) |=> state == PPM_SLEEP) // R19
      else $error("left sleep under sleep bit");
endmodule
`default_nettype wire

// file: rtl/ppm_params.svh
// Contract
// R1: start in power-down until charger seen
// R2: charger active enables supplies, starts machine
// R3: stay in reset loop until cells good
// R4: default cell map is cells 1,2,8
// R5: fets on only when pack conditions good
// R6: load check waits 3s then two clears
// R7: reset loop loads defaults from nonvolatile store
// R8: supply thresholds decide operate or power-down
// R9: normal mode scans every 32ms, balances
// R10: no current for idle time enters idle
// R11: current in idle or doze returns normal
// R12: host scan override stops scans and auto modes
// R13: idle force holds idle until bits cleared
// R14: idle plus idle time enters doze
// R15: doze force holds doze until bits cleared
// R16: zero idle timer goes straight to doze
// R17: low cell voltage for delay enters sleep
// R18: doze plus sleep time enters sleep
// R19: host sleep bit forces sleep
// R20: both timers zero sleeps at once
// R21: sleep wakes on load or charger
// R22: lockout or host command enters power-down
// R23: timers restart on any current
// R24: force priority sleep over doze over idle
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH
`define PPM_CLK_MHZ         125
`define PPM_MS_CYCLES       (`PPM_CLK_MHZ * 1000)
`define PPM_SCAN_NORMAL_MS  32
`define PPM_SCAN_IDLE_MS    256
`define PPM_SCAN_DOZE_MS    512
`define PPM_LOAD_WAIT_MS    3000
`define PPM_LOAD_GAP_MS     256
`define PPM_UNDERVOLTAGE_LOCKOUT_THRESHOLD_MS         160
`define PPM_MIN_MS          60000
`define PPM_SLEEP_STEP_MIN  16
`define PPM_LOAD_PASSES     2'h2
`define PPM_CELLS_DEFAULT   8'h83
`define PPM_BIT_SLEEP       2
`define PPM_BIT_DOZE        1
`define PPM_BIT_IDLE        0
`endif

// file: rtl/ppm_pkg.sv
package ppm_pkg;
   typedef enum logic [2:0] {
      PPM_POWER_DOWN, PPM_POR_LOOP, PPM_LOAD_CHECK, PPM_NORMAL,
      PPM_IDLE, PPM_DOZE, PPM_SLEEP
   } ppm_state_t;
   typedef struct packed {
      logic supply_above_1v;
      logic supply_above_por;
      logic regulator_output_ok;
   } ppm_supply_t;
   typedef struct packed {
      logic scan_override;
      logic sleep;
      logic doze;
      logic idle;
      logic power_down;
   } ppm_host_t;
endpackage

// file: rtl/ppm_tick.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppm_params.svh"
// millisecond and minute tick generator
module ppm_tick
   import ppm_pkg::*;
#(
   parameter int MS_CYCLES  = `PPM_MS_CYCLES,
   parameter int MIN_MS     = `PPM_MIN_MS
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // ticks
   output logic      ms_tick,
   output logic      min_tick
);
   logic [31:0] cyc;
   logic [31:0] msc;
   logic [31:0] next_cyc;
   logic [31:0] next_msc;
   logic        next_ms;
   logic        next_min;
   // free running time base
   always_comb begin
      next_ms = (cyc == 32'(MS_CYCLES - 1));
      next_cyc = next_ms ? 32'h0 : cyc + 32'h1;
      next_min = 1'b0;
      next_msc = msc;
      if (next_ms) begin
         next_min = (msc == 32'(MIN_MS - 1));
         next_msc = next_min ? 32'h0 : msc + 32'h1;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cyc      <= 32'h0;
         msc      <= 32'h0;
         ms_tick  <= 1'b0;
         min_tick <= 1'b0;
      end else begin
         cyc      <= next_cyc;
         msc      <= next_msc;
         ms_tick  <= next_ms;
         min_tick <= next_min;
      end
   end
endmodule
`default_nettype wire

// file: bench/ppm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host controller model: registers mode bits onto the control lines
module ppm_host_model
   import ppm_pkg::*;
(
   // clock and reset
   input  wire logic      clk,
   input  wire logic      sys_rst,
   // requested bits and driven lines
   input  wire ppm_host_t cmd,
   output ppm_host_t      host
);
   // bits change only after a clock edge, cleared while in reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) host <= '0;
      else host <= cmd;
   end
endmodule
`default_nettype wire

// file: bench/ppm_manager_test.sv
`timescale 1ns/100ps
`default_nettype none
module ppm_manager_test
   import ppm_pkg::*;
;
   logic clk = 0, sys_rst = 1, chg = 0, ldp = 1, lp = 1, cur = 1;
   logic flt = 0, bal = 0, lpe = 0;
   ppm_supply_t sup = 3'h7;
   logic [7:0] good = 8'h03, bsl = 0, blo = 0, nvm = 8'hc3;
   logic [7:0] mts = 8'h11, svl = 0, sdl = 8'h0a;
   ppm_host_t cmd = '0, host;
   ppm_state_t state;
   logic sup_on, fets, strobe, bal_on;
   logic [7:0] cmap;
   int err_count = 0, num_checks = 0, cyc = 0, strobes = 0, s0;
   // clock, 8 ns period
   always #4 clk = ~clk;
   ppm_host_model ppm_host_model_inst (.clk(clk), .sys_rst(sys_rst), .cmd(cmd), .host(host));
   ppm_manager #(.MS_CYCLES(4), .MIN_MS(4)) ppm_manager_inst (
      .clk(clk), .sys_rst(sys_rst), .charger_monitor_pin(chg),
      .load_monitor_pin(ldp), .load_present(lp), .current_detect(cur),
      .supply(sup), .cell_good(good), .cell_below_sleep(bsl),
      .cell_below_lockout(blo), .fault_present(flt), .balance_needed(bal),
      .nv_cell_map(nvm), .mode_timer_setting(mts), .sleep_voltage_level(svl),
      .sleep_delay_ms(sdl), .lockout_powerdown_enable(lpe), .host(host),
      .state(state), .supplies_on(sup_on), .fets_on(fets),
      .scan_strobe(strobe), .balance_on(bal_on), .cell_map(cmap));
   // scan pulse counter and hang guard
   always @(posedge clk) begin
      if (strobe === 1'b1) strobes <= strobes + 1;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic chk_st(ppm_state_t e);
      num_checks++;
      if (state !== e) begin
         err_count++;
         $display("CHECK FAILED %0t state %s", $time, state.name());
      end
   endtask
   task automatic chk_b(logic ok, string m);
      num_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic dly(int n);
      repeat (n) @(negedge clk);
   endtask
   // wait a bounded time for a state
   task automatic go(ppm_state_t s, int n);
      for (int i = 0; i < n && state !== s; i++) @(negedge clk);
      chk_st(s);
   endtask
   task automatic t_powerup();
      dly(40);
      chk_st(PPM_POWER_DOWN);
      chk_b(cmap === 8'h83 && sup_on === 1'b0, "reset map");
      @(posedge clk) chg <= 1;
      go(PPM_POR_LOOP, 6);
      chk_b(sup_on === 1'b1, "supplies");
      dly(40);
      chk_st(PPM_POR_LOOP);
      chk_b(cmap === 8'hc3, "map copy");
      @(posedge clk) good <= 8'hc3;
      go(PPM_LOAD_CHECK, 6);
      dly(12500);
      chk_st(PPM_LOAD_CHECK);
      @(posedge clk) lp <= 0;
      dly(900);
      chk_st(PPM_LOAD_CHECK);
      go(PPM_NORMAL, 2300);
      chk_b(fets === 1'b1, "fets on");
      @(posedge clk) flt <= 1;
      dly(4);
      chk_b(fets === 1'b0, "fault fets");
      @(posedge clk) begin
         flt <= 0;
         chg <= 0;
      end
   endtask
   task automatic t_normal();
      @(posedge clk) bal <= 1;
      dly(4);
      chk_b(bal_on === 1'b1, "balance");
      s0 = strobes;
      dly(1280);
      chk_b(strobes - s0 inside {[9:11]}, "scan rate");
   endtask
   task automatic t_auto();
      @(posedge clk) cur <= 0;
      go(PPM_IDLE, 40);
      @(posedge clk) cur <= 1;
      go(PPM_NORMAL, 4);
      @(posedge clk) cur <= 0;
      go(PPM_IDLE, 40);
      go(PPM_DOZE, 40);
      go(PPM_SLEEP, 300);
      chk_b(fets === 1'b0, "sleep fets");
      dly(20);
      chk_st(PPM_SLEEP);
      @(posedge clk) ldp <= 0;
      go(PPM_NORMAL, 6);
      @(posedge clk) begin
         ldp <= 1;
         cur <= 1;
      end
   endtask
   task automatic t_host();
      @(posedge clk) cmd.idle <= 1;
      go(PPM_IDLE, 5);
      dly(60);
      chk_st(PPM_IDLE);
      @(posedge clk) cmd.doze <= 1;
      go(PPM_DOZE, 5);
      @(posedge clk) cmd.sleep <= 1;
      go(PPM_SLEEP, 5);
      @(posedge clk) cmd <= '0;
      go(PPM_NORMAL, 6);
      @(posedge clk) begin
         cmd.scan_override <= 1;
         cur <= 0;
      end
      dly(3);
      s0 = strobes;
      dly(100);
      chk_st(PPM_NORMAL);
      chk_b(strobes === s0, "no scans");
      @(posedge clk) cmd <= '0;
   endtask
   task automatic t_zero();
      @(posedge clk) mts <= 8'h10;
      go(PPM_DOZE, 5);
      @(posedge clk) cur <= 1;
      go(PPM_NORMAL, 4);
      @(posedge clk) begin
         mts <= 8'h00;
         cur <= 0;
      end
      go(PPM_SLEEP, 5);
      @(posedge clk) cur <= 1;
      go(PPM_NORMAL, 6);
      @(posedge clk) mts <= 8'hff;
   endtask
   task automatic t_volt();
      @(posedge clk) begin
         cur <= 0;
         bsl <= 8'h01;
      end
      dly(60);
      chk_st(PPM_NORMAL);
      @(posedge clk) svl <= 8'h20;
      dly(30);
      chk_st(PPM_NORMAL);
      go(PPM_SLEEP, 30);
      @(posedge clk) begin
         bsl <= 0;
         cur <= 1;
      end
      go(PPM_NORMAL, 6);
   endtask
   task automatic t_supply();
      @(posedge clk) sup <= 3'h5;
      dly(20);
      chk_st(PPM_NORMAL);
      @(posedge clk) sup <= 3'h1;
      go(PPM_POWER_DOWN, 4);
      chk_b(sup_on === 1'b0 && fets === 1'b0, "dropout off");
      @(posedge clk) begin
         sup <= 3'h7;
         chg <= 1;
      end
      go(PPM_LOAD_CHECK, 8);
      go(PPM_NORMAL, 16000);
      @(posedge clk) chg <= 0;
   endtask
   task automatic t_lockout();
      @(posedge clk) begin
         lpe <= 1;
         blo <= 8'h01;
      end
      dly(600);
      chk_st(PPM_NORMAL);
      go(PPM_POWER_DOWN, 100);
      chk_b(sup_on === 1'b0, "supplies off");
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 0;
      t_powerup();
      t_normal();
      t_auto();
      t_host();
      t_zero();
      t_volt();
      t_supply();
      t_lockout();
      stop_test();
   end
endmodule
`default_nettype wire
